// ===== hw/fblk_pkg.sv
// package: constants and types for the flash block lock state machine
package fblk_pkg;
   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int unsigned NUM_BLOCKS = 16;
   localparam int unsigned BLK_AW     = 4;

   // ----------------------------------------------------------------
   // protection status read layout (identifier mode)
   // ----------------------------------------------------------------
   localparam logic [1:0] STATUS_ADDR_SEL = 2'h2;
   localparam int unsigned LOCK_BIT       = 0;
   localparam int unsigned LOCKDOWN_BIT   = 1;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RST_LOCK     = 1'h1;
   localparam logic RST_LOCKDOWN = 1'h0;

   // ----------------------------------------------------------------
   // commands
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FBLK_CMD_LOCK     = 2'h0,
      FBLK_CMD_UNLOCK   = 2'h1,
      FBLK_CMD_LOCKDOWN = 2'h2
   } fblk_cmd_t;

   // ----------------------------------------------------------------
   // operation state of the array
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      FBLK_IDLE       = 5'h01,
      FBLK_ERASING    = 5'h02,
      FBLK_ERASE_SUSP = 5'h04,
      FBLK_PROGRAMING = 5'h08,
      FBLK_PROG_SUSP  = 5'h10
   } fblk_state_t;
endpackage

// ===== hw/fblk_lock.sv
// module: per-block lock and lock-down state with write-protect gating
`timescale 1ns/1ps
`default_nettype none
module fblk_lock (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   // write-protect pin, high disables lock-down
   input  wire logic                        wp,
   // lock commands
   input  wire logic                        cmd_valid,
   input  wire logic [1:0]                  cmd_op,
   input  wire logic [fblk_pkg::BLK_AW-1:0] cmd_block,
   // array operations
   input  wire logic                        op_start,
   input  wire logic                        op_is_erase,
   input  wire logic [fblk_pkg::BLK_AW-1:0] op_block,
   input  wire logic                        op_suspend,
   input  wire logic                        op_resume,
   input  wire logic                        op_finish,
   // status read
   input  wire logic                        rd_en,
   input  wire logic [1:0]                  rd_addr,
   input  wire logic [fblk_pkg::BLK_AW-1:0] rd_block,
   // results
   output logic [15:0]                      rd_data,
   output logic                             op_error,
   output logic                             erase_busy,
   output logic                             prog_busy,
   output logic                             op_suspended,
   output logic [fblk_pkg::NUM_BLOCKS-1:0]  block_lock_flag,
   output logic [fblk_pkg::NUM_BLOCKS-1:0]  block_lockdown_flag
);
   localparam int unsigned N  = fblk_pkg::NUM_BLOCKS;
   localparam int unsigned AW = fblk_pkg::BLK_AW;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   fblk_pkg::fblk_state_t state;
   fblk_pkg::fblk_state_t next_state;
   logic [N-1:0] saved_lock;
   logic         wp_prev;
   logic [N-1:0] next_lock_flag;
   logic [N-1:0] next_lockdown_flag;
   logic [N-1:0] next_saved_lock;
   logic [15:0]  next_rd_data;
   logic         next_op_error;
   logic         next_erase_busy;
   logic         next_prog_busy;
   logic         next_op_suspended;

   // locked-down block whose flags are frozen while protect is low
   function automatic logic frozen(input logic ld, input logic wpl);
      return ld && !wpl;
   endfunction

   wire logic wp_rise = wp && !wp_prev;
   wire logic wp_fall = !wp && wp_prev;
   // commands dropped while a program is suspended, accepted elsewhere
   wire logic cmd_ok  = cmd_valid &&
                        (state != fblk_pkg::FBLK_PROG_SUSP);

   // ----------------------------------------------------------------
   // per-block flag update
   // ----------------------------------------------------------------
   // saved_lock tracks the lock value chosen while protect is high, so
   // a later rise can bring it back after the forced lock on the fall
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_blk
         always_comb begin
            next_lock_flag[g]     = block_lock_flag[g];
            next_lockdown_flag[g] = block_lockdown_flag[g];
            next_saved_lock[g]    = saved_lock[g];
            if (cmd_ok && cmd_block == AW'(g) &&
                !frozen(block_lockdown_flag[g], wp)) begin
               unique case (cmd_op)
                  fblk_pkg::FBLK_CMD_LOCK: begin
                     next_lock_flag[g]  = 1'h1;
                     next_saved_lock[g] = 1'h1;
                  end
                  fblk_pkg::FBLK_CMD_UNLOCK: begin
                     next_lock_flag[g]  = 1'h0;
                     next_saved_lock[g] = 1'h0;
                  end
                  fblk_pkg::FBLK_CMD_LOCKDOWN: begin
                     next_lock_flag[g]     = 1'h1;
                     next_lockdown_flag[g] = 1'h1;
                     next_saved_lock[g]    = 1'h1;
                  end
                  default: ;
               endcase
            end
            if (wp_fall && block_lockdown_flag[g]) begin
               next_lock_flag[g] = 1'h1;
            end
            if (wp_rise && block_lockdown_flag[g]) begin
               next_lock_flag[g] = saved_lock[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // operation sequencing
   // ----------------------------------------------------------------
   wire logic [N-1:0] prot = block_lock_flag;

   always_comb begin
      next_state    = state;
      next_op_error = 1'h0;
      unique case (state)
         fblk_pkg::FBLK_IDLE, fblk_pkg::FBLK_ERASE_SUSP: begin
            if (op_resume && state == fblk_pkg::FBLK_ERASE_SUSP) begin
               next_state = fblk_pkg::FBLK_ERASING;
            end else if (op_start) begin
               // only a program may start while an erase is parked
               if (prot[op_block]) begin
                  next_op_error = 1'h1;
               end else if (op_is_erase &&
                            state == fblk_pkg::FBLK_IDLE) begin
                  next_state = fblk_pkg::FBLK_ERASING;
               end else if (!op_is_erase) begin
                  next_state = fblk_pkg::FBLK_PROGRAMING;
               end
            end
         end
         fblk_pkg::FBLK_ERASING: begin
            // lock state is not rechecked here: erase finishes
            if (op_finish) next_state = fblk_pkg::FBLK_IDLE;
            else if (op_suspend) next_state = fblk_pkg::FBLK_ERASE_SUSP;
         end
         fblk_pkg::FBLK_PROGRAMING: begin
            if (op_finish) next_state = fblk_pkg::FBLK_IDLE;
            else if (op_suspend) next_state = fblk_pkg::FBLK_PROG_SUSP;
         end
         fblk_pkg::FBLK_PROG_SUSP: begin
            if (op_resume) next_state = fblk_pkg::FBLK_PROGRAMING;
         end
         default: next_state = fblk_pkg::FBLK_IDLE;
      endcase
      next_erase_busy   = next_state == fblk_pkg::FBLK_ERASING;
      next_prog_busy    = next_state == fblk_pkg::FBLK_PROGRAMING;
      next_op_suspended = next_state == fblk_pkg::FBLK_ERASE_SUSP ||
                          next_state == fblk_pkg::FBLK_PROG_SUSP;
   end

   // ----------------------------------------------------------------
   // status read
   // ----------------------------------------------------------------
   always_comb begin
      next_rd_data = rd_data;
      // other identifier addresses read as zero in this block
      if (rd_en) begin
         next_rd_data = 16'h0000;
         if (rd_addr == fblk_pkg::STATUS_ADDR_SEL) begin
            next_rd_data[fblk_pkg::LOCK_BIT]     = block_lock_flag[rd_block];
            next_rd_data[fblk_pkg::LOCKDOWN_BIT] =
               block_lockdown_flag[rd_block];
         end
      end
   end

   // ----------------------------------------------------------------
   // flag registers
   // ----------------------------------------------------------------
   // wp_prev clears low, so a high pin at release looks like a rise;
   // harmless, as no block is locked down straight after reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         block_lock_flag     <= {N{fblk_pkg::RST_LOCK}};
         block_lockdown_flag <= {N{fblk_pkg::RST_LOCKDOWN}};
         saved_lock          <= {N{fblk_pkg::RST_LOCK}};
         wp_prev             <= 1'h0;
      end else begin
         block_lock_flag     <= next_lock_flag;
         block_lockdown_flag <= next_lockdown_flag;
         saved_lock          <= next_saved_lock;
         wp_prev             <= wp;
      end
   end

   // ----------------------------------------------------------------
   // sequencing registers
   // ----------------------------------------------------------------
   // busy and suspend levels are copies of the next state, so they line
   // up with state and need no decode on the output path
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state        <= fblk_pkg::FBLK_IDLE;
         op_error     <= 1'h0;
         erase_busy   <= 1'h0;
         prog_busy    <= 1'h0;
         op_suspended <= 1'h0;
      end else begin
         state        <= next_state;
         op_error     <= next_op_error;
         erase_busy   <= next_erase_busy;
         prog_busy    <= next_prog_busy;
         op_suspended <= next_op_suspended;
      end
   end

   // ----------------------------------------------------------------
   // read register
   // ----------------------------------------------------------------
   // the read word holds between reads so a slow host may sample late
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 16'h0000;
      end else begin
         rd_data <= next_rd_data;
      end
   end
endmodule // fblk_lock
`default_nettype wire

// ===== tb/fblk_lock_checker.sv
// checker: concurrent properties on the lock block ports
`timescale 1ns/1ps
`default_nettype none
module fblk_lock_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // requests
   input wire logic        wp,
   input wire logic        cmd_valid,
   input wire logic [1:0]  cmd_op,
   input wire logic [3:0]  cmd_block,
   input wire logic        op_start,
   input wire logic [3:0]  op_block,
   input wire logic        rd_en,
   input wire logic [1:0]  rd_addr,
   input wire logic [3:0]  rd_block,
   // results
   input wire logic [15:0] rd_data,
   input wire logic        op_error,
   input wire logic        erase_busy,
   input wire logic        prog_busy,
   input wire logic        op_suspended,
   input wire logic [15:0] block_lock_flag,
   input wire logic [15:0] block_lockdown_flag
);
   // suspend alone cannot tell a program from an erase, so remember which
   logic susp_prog;
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) susp_prog <= 1'h0;
      else if (erase_busy | prog_busy) susp_prog <= prog_busy;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   rst_state_a: assert property ($rose(reset_n) |->
      &block_lock_flag && block_lockdown_flag == 16'h0) else $error("reset");
   ld_cmd_a: assert property (cmd_valid && cmd_op == 2'h2 &&
      $stable(wp) && !(op_suspended && susp_prog) |=>
      block_lockdown_flag[$past(cmd_block)] &&
      block_lock_flag[$past(cmd_block)]) else $error("lockdown");
   prog_susp_a: assert property (cmd_valid && op_suspended &&
      susp_prog && $stable(wp) |=> $stable(block_lock_flag) &&
      $stable(block_lockdown_flag)) else $error("prog susp");
   ld_kept_a: assert property (cmd_valid && !wp && $stable(wp) &&
      block_lockdown_flag[cmd_block] |=> block_lock_flag[$past(cmd_block)])
      else $error("locked-down changed");
   wp_fall_a: assert property ($fell(wp) |=>
      &(block_lock_flag | ~block_lockdown_flag)) else $error("wp fall");
   ld_sticky_a: assert property (
      ($past(block_lockdown_flag) & ~block_lockdown_flag) == 16'h0)
      else $error("lockdown cleared");
   lock_err_a: assert property (op_start && block_lock_flag[op_block] &&
      !(erase_busy || prog_busy || op_suspended) |=> op_error && !erase_busy
      && !prog_busy) else $error("locked op");
   rd_stat_a: assert property (rd_en &&
      rd_addr == fblk_pkg::STATUS_ADDR_SEL |=> rd_data == {14'h0,
      $past(block_lockdown_flag[rd_block]),
      $past(block_lock_flag[rd_block])}) else $error("status read");
   cover property (cmd_valid && op_suspended && !susp_prog);
   cover property ($rose(wp) && |block_lockdown_flag);
   cover property (op_error);
endmodule // fblk_lock_checker
bind fblk_lock fblk_lock_checker i_fblk_lock_checker (
   .clk                 (clk),
   .reset_n             (reset_n),
   .wp                  (wp),
   .cmd_valid           (cmd_valid),
   .cmd_op              (cmd_op),
   .cmd_block           (cmd_block),
   .op_start            (op_start),
   .op_block            (op_block),
   .rd_en               (rd_en),
   .rd_addr             (rd_addr),
   .rd_block            (rd_block),
   .rd_data             (rd_data),
   .op_error            (op_error),
   .erase_busy          (erase_busy),
   .prog_busy           (prog_busy),
   .op_suspended        (op_suspended),
   .block_lock_flag     (block_lock_flag),
   .block_lockdown_flag (block_lockdown_flag)
);
`default_nettype wire

// ===== tb/fblk_host.sv
// partner model: host issuing lock commands, array operations and reads
`timescale 1ns/1ps
`default_nettype none
module fblk_host (
   // clock
   input  wire logic  clk,
   // strobes and qualifiers
   output logic       cmd_valid,
   output logic [1:0] cmd_op,
   output logic [3:0] cmd_block,
   output logic       op_start,
   output logic       op_is_erase,
   output logic [3:0] op_block,
   output logic       op_suspend,
   output logic       op_resume,
   output logic       op_finish,
   output logic       rd_en,
   output logic [1:0] rd_addr,
   output logic [3:0] rd_block
);
   logic [5:0] s = 6'h0;
   logic [1:0] o = 2'h0;
   logic [3:0] b = 4'h0;
   assign {cmd_valid, op_start, op_suspend, op_resume, op_finish, rd_en} = s;
   assign {cmd_op, rd_addr, cmd_block, op_block, rd_block} = {o, o, b, b, b};
   assign op_is_erase = o[0];
   // one strobe for one edge; locking in program suspend only when asked
   task automatic go(input logic [5:0] st, input logic [1:0] op,
                     input logic [3:0] blk);
      @(posedge clk);
      s <= st;
      o <= op;
      b <= blk;
      @(posedge clk);
      s <= 6'h0;
   endtask
endmodule // fblk_host
`default_nettype wire

// ===== tb/fblk_lock_tb.sv
// testbench: scenarios for the block lock state machine
`timescale 1ns/1ps
`default_nettype none
module fblk_lock_tb;
   localparam logic [5:0] CMD = 6'h20, ST = 6'h10, SU = 6'h08, RS = 6'h04;
   localparam logic [5:0] FN = 6'h02, RD = 6'h01;
   logic clk = 1'h0, reset_n = 1'h0, wp = 1'h0;
   wire cmd_valid, op_start, op_is_erase, op_suspend, op_resume, op_finish;
   wire rd_en, op_error, erase_busy, prog_busy, op_suspended;
   wire [1:0] cmd_op, rd_addr;
   wire [3:0] cmd_block, op_block, rd_block;
   wire [15:0] rd_data, block_lock_flag, block_lockdown_flag;
   int n_fail = 0, checks_done = 0;
   fblk_host i_fblk_host (
      .clk         (clk),
      .cmd_valid   (cmd_valid),
      .cmd_op      (cmd_op),
      .cmd_block   (cmd_block),
      .op_start    (op_start),
      .op_is_erase (op_is_erase),
      .op_block    (op_block),
      .op_suspend  (op_suspend),
      .op_resume   (op_resume),
      .op_finish   (op_finish),
      .rd_en       (rd_en),
      .rd_addr     (rd_addr),
      .rd_block    (rd_block)
   );
   fblk_lock i_fblk_lock (
      .clk                 (clk),
      .reset_n             (reset_n),
      .wp                  (wp),
      .cmd_valid           (cmd_valid),
      .cmd_op              (cmd_op),
      .cmd_block           (cmd_block),
      .op_start            (op_start),
      .op_is_erase         (op_is_erase),
      .op_block            (op_block),
      .op_suspend          (op_suspend),
      .op_resume           (op_resume),
      .op_finish           (op_finish),
      .rd_en               (rd_en),
      .rd_addr             (rd_addr),
      .rd_block            (rd_block),
      .rd_data             (rd_data),
      .op_error            (op_error),
      .erase_busy          (erase_busy),
      .prog_busy           (prog_busy),
      .op_suspended        (op_suspended),
      .block_lock_flag     (block_lock_flag),
      .block_lockdown_flag (block_lockdown_flag)
   );
   initial forever #5 clk = ~clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic g(input logic [5:0] st, input logic [1:0] o, logic [3:0] b);
      i_fblk_host.go(st, o, b);
      @(negedge clk);
   endtask
   // status bits: error, erase busy, program busy, suspended
   task automatic st4(input logic [3:0] e);
      chk({12'h0, op_error, erase_busy, prog_busy, op_suspended}, {12'h0, e});
   endtask
   task automatic rd(input logic [3:0] b, input logic [15:0] e);
      g(RD, 2'h2, b);
      chk(rd_data, e);
   endtask
   task automatic setwp(input logic v);
      @(posedge clk);
      wp <= v;
      @(posedge clk);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      report_and_stop;
   end
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'h1;
      rd(4'h5, 16'h1);
      chk(block_lock_flag, 16'hFFFF);
      chk(block_lockdown_flag, 16'h0);
      g(RD, 2'h0, 4'h5);
      chk(rd_data, 16'h0);
      g(CMD, 2'h3, 4'h5);
      rd(4'h5, 16'h1);
      g(CMD, 2'h1, 4'h2);
      g(ST, 2'h1, 4'h2);
      st4(4'h4);
      g(SU, 2'h0, 4'h2);
      g(CMD, 2'h2, 4'h2);
      rd(4'h2, 16'h3);
      g(ST, 2'h0, 4'h2);
      st4(4'h9);
      g(RS, 2'h0, 4'h2);
      st4(4'h4);
      g(FN, 2'h0, 4'h2);
      st4(4'h0);
      g(ST, 2'h1, 4'h2);
      st4(4'h8);
      g(CMD, 2'h1, 4'h6);
      g(ST, 2'h0, 4'h6);
      st4(4'h2);
      g(SU, 2'h0, 4'h6);
      st4(4'h1);
      g(CMD, 2'h0, 4'h6);
      rd(4'h6, 16'h0);
      g(RS, 2'h0, 4'h6);
      g(FN, 2'h0, 4'h6);
      g(ST, 2'h0, 4'h3);
      st4(4'h8);
      g(CMD, 2'h1, 4'h4);
      g(CMD, 2'h2, 4'h4);
      rd(4'h4, 16'h3);
      g(CMD, 2'h1, 4'h4);
      rd(4'h4, 16'h3);
      setwp(1'h1);
      rd(4'h4, 16'h3);
      g(CMD, 2'h1, 4'h4);
      rd(4'h4, 16'h2);
      g(CMD, 2'h0, 4'h4);
      rd(4'h4, 16'h3);
      g(CMD, 2'h1, 4'h4);
      setwp(1'h0);
      rd(4'h4, 16'h3);
      setwp(1'h1);
      rd(4'h4, 16'h2);
      @(posedge clk);
      reset_n <= 1'h0;
      repeat (16) @(posedge clk);
      reset_n <= 1'h1;
      rd(4'h4, 16'h1);
      report_and_stop;
   end
endmodule // fblk_lock_tb
`default_nettype wire
